// ===== hdl/ptt_timers.sv
// periodic tick timer and task monitor timer
`timescale 1ns/10ps
module ptt_timers (
  input  wire logic                                           clk_i,
  input  wire logic                                           rst_i,
  input  wire logic                                           xtal_tick_i,
  input  wire logic                                           stop_mode_i,
  input  wire logic                                           debug_mode_i,
  input  wire ptt_pkg::ptt_pit_cfg_t [ptt_pkg::PTT_NUM_CH-1:0]  pit_cfg_i,
  input  wire ptt_pkg::ptt_tmt_cfg_t                            tmt_cfg_i,
  input  wire ptt_pkg::ptt_cmp_cfg_t [ptt_pkg::PTT_NUM_CMP-1:0] cmp_cfg_i,
  output logic [ptt_pkg::PTT_NUM_CH-1:0]                        pit_irq_o,
  output logic [ptt_pkg::PTT_NUM_CH-1:0]                        pit_trig_o,
  output logic                                                  wake_o,
  output logic [ptt_pkg::PTT_CNT_W-1:0]                         tmt_count_o,
  output logic [ptt_pkg::PTT_NUM_CMP-1:0]                       cmp_irq_o
);
  import ptt_pkg::*;

  //--------------------------------------------------------------
  // helpers
  //--------------------------------------------------------------
  // one step down of a periodic count
  function automatic logic [PTT_CNT_W-1:0] cnt_dec(input logic [PTT_CNT_W-1:0] v);
    cnt_dec = v - PTT_CNT_ONE;
  endfunction : cnt_dec

  // one step up of the task monitor count, wraps from all ones
  function automatic logic [PTT_CNT_W-1:0] cnt_inc(input logic [PTT_CNT_W-1:0] v);
    cnt_inc = v + PTT_CNT_ONE;
  endfunction : cnt_inc

  function automatic logic cnt_is_zero(input logic [PTT_CNT_W-1:0] v);
    cnt_is_zero = (v == PTT_CNT_ZERO);
  endfunction : cnt_is_zero

  function automatic logic cnt_is_one(input logic [PTT_CNT_W-1:0] v);
    cnt_is_one = (v == PTT_CNT_ONE);
  endfunction : cnt_is_one

  // expiry on a tick: last step down, or a zero start value at zero
  function automatic logic pit_expires(input logic [PTT_CNT_W-1:0] cnt,
                                       input logic [PTT_CNT_W-1:0] start);
    pit_expires = cnt_is_one(cnt) | (cnt_is_zero(cnt) & cnt_is_zero(start));
  endfunction : pit_expires

  // next periodic count on a tick; zero spends one tick reloading
  function automatic logic [PTT_CNT_W-1:0] pit_next(input logic [PTT_CNT_W-1:0] cnt,
                                                    input logic [PTT_CNT_W-1:0] start);
    if (cnt_is_zero(cnt)) begin
      pit_next = start;
    end else begin
      pit_next = cnt_dec(cnt);
    end
  endfunction : pit_next

  // prescaler period complete; a lowered limit wraps at once
  function automatic logic pre_done(input logic [PTT_PRE_W-1:0] pre,
                                    input logic [PTT_PRE_W-1:0] limit);
    pre_done = (pre >= limit);
  endfunction : pre_done

  //--------------------------------------------------------------
  // periodic tick timer channels
  //--------------------------------------------------------------
  logic [PTT_CNT_W-1:0] pit_cnt_q [PTT_NUM_CH];
  logic [PTT_CNT_W-1:0] pit_cnt_d [PTT_NUM_CH];
  logic [PTT_NUM_CH-1:0] pit_irq_q, pit_irq_d;
  logic [PTT_NUM_CH-1:0] pit_trig_q, pit_trig_d;
  logic                  wake_q, wake_d;
  logic [PTT_NUM_CH-1:0] ch_tick;
  logic [PTT_NUM_CH-1:0] ch_zero;

  always_comb begin
    for (int i = 0; i < PTT_NUM_CH; i++) begin
      // wake channel on crystal enable, even in stop; others stop with clock
      if (i == PTT_WAKE_CH) begin
        ch_tick[i] = xtal_tick_i;
      end else begin
        ch_tick[i] = ~stop_mode_i;
      end
    end
  end

  always_comb begin
    for (int i = 0; i < PTT_NUM_CH; i++) begin
      pit_cnt_d[i]  = pit_cnt_q[i];
      pit_irq_d[i]  = 1'b0;
      pit_trig_d[i] = 1'b0;
      ch_zero[i]    = 1'b0;
      if (!pit_cfg_i[i].enable) begin
        pit_cnt_d[i] = pit_cfg_i[i].start_val;
      end else if (ch_tick[i]) begin
        // a start value of zero expires on every tick
        pit_cnt_d[i] = pit_next(pit_cnt_q[i], pit_cfg_i[i].start_val);
        ch_zero[i]   = pit_expires(pit_cnt_q[i], pit_cfg_i[i].start_val);
      end
      pit_irq_d[i]  = ch_zero[i] & pit_cfg_i[i].irq_en;
      pit_trig_d[i] = ch_zero[i] & pit_cfg_i[i].trig_en;
    end
  end

  // wake request only while stopped; outside stop the irq path serves
  always_comb begin
    wake_d = ch_zero[PTT_WAKE_CH] & stop_mode_i;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < PTT_NUM_CH; i++) begin
        pit_cnt_q[i] <= PTT_CNT_ZERO;
      end
      pit_irq_q  <= '0;
      pit_trig_q <= '0;
      wake_q     <= 1'b0;
    end else begin
      for (int i = 0; i < PTT_NUM_CH; i++) begin
        pit_cnt_q[i] <= pit_cnt_d[i];
      end
      pit_irq_q  <= pit_irq_d;
      pit_trig_q <= pit_trig_d;
      wake_q     <= wake_d;
    end
  end

  //--------------------------------------------------------------
  // periodic outputs
  //--------------------------------------------------------------
  // internal signals only, no pins
  assign pit_irq_o  = pit_irq_q;
  assign pit_trig_o = pit_trig_q;
  assign wake_o     = wake_q;

  //--------------------------------------------------------------
  // task monitor timer
  //--------------------------------------------------------------
  logic [PTT_PRE_W-1:0]   pre_q, pre_d;
  logic [PTT_CNT_W-1:0]   tmt_q, tmt_d;
  logic [PTT_NUM_CMP-1:0] cmp_q, cmp_d;
  logic                   tmt_run;

  // prescaler and counter group
  always_comb begin
    tmt_run = tmt_cfg_i.enable & ~(debug_mode_i & tmt_cfg_i.freeze_dbg);
    pre_d   = pre_q;
    tmt_d   = tmt_q;
    if (tmt_run) begin
      if (pre_done(pre_q, tmt_cfg_i.prescale)) begin
        // divide by prescale+1, counter wraps naturally
        pre_d = PTT_PRE_ZERO;
        tmt_d = cnt_inc(tmt_q);
      end else begin
        pre_d = pre_q + PTT_PRE_ONE;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre_q <= PTT_PRE_ZERO;
      tmt_q <= PTT_CNT_ZERO;
    end else begin
      pre_q <= pre_d;
      tmt_q <= tmt_d;
    end
  end

  //--------------------------------------------------------------
  // compare channels
  //--------------------------------------------------------------
  // level interrupt with no clear; follows the count one cycle late
  always_comb begin
    for (int c = 0; c < PTT_NUM_CMP; c++) begin
      cmp_d[c] = cmp_cfg_i[c].enable & (tmt_q > cmp_cfg_i[c].value);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmp_q <= '0;
    end else begin
      cmp_q <= cmp_d;
    end
  end

  //--------------------------------------------------------------
  // task monitor outputs
  //--------------------------------------------------------------
  assign tmt_count_o = tmt_q;
  assign cmp_irq_o   = cmp_q;

endmodule : ptt_timers

// ===== inc/ptt_pkg.sv
// constants and carrier types for the periodic and task timers
//--------------------------------------------------------------
// Notes on behaviour
// - five periodic channels, 32-bit auto-reload down counters
// - four channels on system clock, one crystal
// - crystal channel runs in stop, wakes device
// - zero raises interrupt, queue trigger, or both
// - no pins; only internal interrupt and trigger outputs
// - task monitor: 32-bit up counter, 8-bit prescaler
// - four 32-bit compare channels, separate interrupts
// - interrupt when counter exceeds compare value
// - counter optionally halts in debug mode
//--------------------------------------------------------------
package ptt_pkg;

  localparam int unsigned PTT_NUM_CH   = 5;
  localparam int unsigned PTT_WAKE_CH  = 4;
  localparam int unsigned PTT_CNT_W    = 32;
  localparam int unsigned PTT_PRE_W    = 8;
  localparam int unsigned PTT_NUM_CMP  = 4;

  localparam logic [PTT_CNT_W-1:0] PTT_CNT_ZERO = 32'h0000_0000;
  localparam logic [PTT_CNT_W-1:0] PTT_CNT_ONE  = 32'h0000_0001;
  localparam logic [PTT_PRE_W-1:0] PTT_PRE_ZERO = 8'h00;
  localparam logic [PTT_PRE_W-1:0] PTT_PRE_ONE  = 8'h01;

  // one periodic channel
  typedef struct packed {
    logic                 enable;
    logic                 irq_en;
    logic                 trig_en;
    logic [PTT_CNT_W-1:0] start_val;
  } ptt_pit_cfg_t;

  // task monitor counter
  typedef struct packed {
    logic                 enable;
    logic                 freeze_dbg;
    logic [PTT_PRE_W-1:0] prescale;
  } ptt_tmt_cfg_t;

  // one compare channel
  typedef struct packed {
    logic                 enable;
    logic [PTT_CNT_W-1:0] value;
  } ptt_cmp_cfg_t;

endpackage : ptt_pkg

// ===== verification/ptt_timers_checker.sv
// assertions on the periodic and task timer ports
`timescale 1ns/10ps
module ptt_timers_checker
  import ptt_pkg::*;
(
  input wire logic                                clk_i,
  input wire logic                                rst_i,
  input wire logic                                xtal_tick_i,
  input wire logic                                stop_mode_i,
  input wire logic                                debug_mode_i,
  input wire ptt_pit_cfg_t [PTT_NUM_CH-1:0]       pit_cfg_i,
  input wire ptt_tmt_cfg_t                        tmt_cfg_i,
  input wire ptt_cmp_cfg_t [PTT_NUM_CMP-1:0]      cmp_cfg_i,
  input wire logic [PTT_NUM_CH-1:0]               pit_irq_o,
  input wire logic [PTT_NUM_CH-1:0]               pit_trig_o,
  input wire logic                                wake_o,
  input wire logic [PTT_CNT_W-1:0]                tmt_count_o,
  input wire logic [PTT_NUM_CMP-1:0]              cmp_irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence trig_off; !pit_cfg_i[0].trig_en ##1 !pit_cfg_i[0].trig_en; endsequence
  sequence run4; (tmt_cfg_i.enable && !(debug_mode_i && tmt_cfg_i.freeze_dbg) && tmt_cfg_i.prescale == 8'h03) [*4];
  endsequence
  chk_irq_one_pulse: assert property (pit_irq_o[0] && pit_cfg_i[0].start_val != 0 |=> !pit_irq_o[0])
    else $error("irq longer than one cycle");
  chk_trig_gated: assert property (trig_off |-> !pit_trig_o[0])
    else $error("trigger while disabled");
  chk_disabled_quiet: assert property (!pit_cfg_i[2].enable [*2] |-> !pit_irq_o[2])
    else $error("disabled channel fired");
  chk_stop_freeze: assert property (stop_mode_i [*2] |=> pit_irq_o[3:0] == 4'h0)
    else $error("system channel fired in stop");
  chk_wake_in_stop: assert property (wake_o |-> $past(stop_mode_i))
    else $error("wake outside stop");
  chk_tmt_step: assert property (run4 |=> tmt_count_o - $past(tmt_count_o, 4) == 32'h1)
    else $error("wrong prescaled step");
  chk_tmt_halt: assert property (!tmt_cfg_i.enable || (debug_mode_i && tmt_cfg_i.freeze_dbg) |=> $stable(tmt_count_o))
    else $error("counter moved while halted");
  for (genvar k = 0; k < PTT_NUM_CMP; k++) begin : g_cmp
    chk_cmp_exceed: assert property (##1 cmp_irq_o[k] == $past(cmp_cfg_i[k].enable && tmt_count_o > cmp_cfg_i[k].value))
      else $error("compare irq wrong");
  end
endmodule : ptt_timers_checker
bind ptt_timers ptt_timers_checker u_chk (.clk_i, .rst_i, .xtal_tick_i, .stop_mode_i, .debug_mode_i, .pit_cfg_i,
  .tmt_cfg_i, .cmp_cfg_i, .pit_irq_o, .pit_trig_o, .wake_o, .tmt_count_o, .cmp_irq_o);

// ===== verification/ptt_timers_tb.sv
// self-checking bench for the periodic and task timers
`timescale 1ns/10ps
module ptt_timers_tb;
  import ptt_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, xtal_tick_i = 1'b0, stop_mode_i = 1'b0, debug_mode_i = 1'b0;
  ptt_pit_cfg_t [PTT_NUM_CH-1:0]  pit_cfg_i = '0;
  ptt_tmt_cfg_t                   tmt_cfg_i = '0;
  ptt_cmp_cfg_t [PTT_NUM_CMP-1:0] cmp_cfg_i = '0;
  logic [PTT_NUM_CH-1:0]          pit_irq_o, pit_trig_o;
  logic                           wake_o;
  logic [PTT_CNT_W-1:0]           tmt_count_o, c;
  logic [PTT_NUM_CMP-1:0]         cmp_irq_o;
  int miscompares = 0, checked = 0, cycles = 0, n;
  ptt_timers dut (.clk_i, .rst_i, .xtal_tick_i, .stop_mode_i, .debug_mode_i, .pit_cfg_i, .tmt_cfg_i,
    .cmp_cfg_i, .pit_irq_o, .pit_trig_o, .wake_o, .tmt_count_o, .cmp_irq_o);
  always #20 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares++;
      report_and_stop();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : report_and_stop
  task automatic next_step();
    c = tmt_count_o;
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (tmt_count_o === c && n < 30);
  endtask : next_step
  task automatic pit_period();
    pit_cfg_i[0] = '{1'b1, 1'b1, 1'b0, 32'h2};
    pit_cfg_i[1] = '{1'b1, 1'b0, 1'b1, 32'h2};
    for (int i = 0; i < 2; i++) begin
      n = 0;
      do begin
        @(negedge clk_i);
        n++;
      end while (pit_irq_o[0] !== 1'b1 && n < 30);
    end
    check(n, 3);
    check(pit_trig_o[1], 1'b1);
    check(pit_irq_o[1], 1'b0);
    check(pit_trig_o[0], 1'b0);
  endtask : pit_period
  task automatic tmt_run();
    tmt_cfg_i = '{1'b1, 1'b1, 8'h03};
    next_step();
    next_step();
    check(n, 4);
    debug_mode_i = 1'b1;
    c = tmt_count_o;
    repeat (6) @(negedge clk_i);
    check(tmt_count_o, c);
    debug_mode_i = 1'b0;
    cmp_cfg_i[1] = '{1'b1, tmt_count_o + 32'h1};
    @(negedge clk_i);
    check(cmp_irq_o[1], 1'b0);
    repeat (12) @(negedge clk_i);
    check(cmp_irq_o[1], 1'b1);
  endtask : tmt_run
  task automatic wake_run();
    pit_cfg_i[4] = '{1'b1, 1'b0, 1'b0, 32'h1};
    stop_mode_i = 1'b1;
    n = 0;
    while (wake_o !== 1'b1 && n < 40) begin
      @(negedge clk_i);
      xtal_tick_i = n[0];
      n++;
    end
    check(wake_o, 1'b1);
    check(pit_irq_o, 5'h00);
    stop_mode_i = 1'b0;
  endtask : wake_run
  initial begin
    repeat (8) @(negedge clk_i);
    rst_i = 1'b0;
    @(negedge clk_i);
    pit_period();
    tmt_run();
    wake_run();
    report_and_stop();
  end
endmodule : ptt_timers_tb
